// file: rtl/irl_regs.vh
// register map, field positions, reset values and timing constants of the ingress rate limiter
`ifndef IRL_REGS_VH
`define IRL_REGS_VH

// ********************************************************************
// register indices (word number), byte address is four times the index
// ********************************************************************
`define IRL_IDX_CFG 10'h003
`define IRL_IDX_P0 10'h010
`define IRL_IDX_P7 10'h017
`define IRL_IDX_PCTL 10'h018
`define IRL_IDX_STAT 10'h019
`define IRL_ADDR_CFG ({`IRL_IDX_CFG, 2'b00})
`define IRL_ADDR_P0 ({`IRL_IDX_P0, 2'b00})
`define IRL_ADDR_P7 ({`IRL_IDX_P7, 2'b00})
`define IRL_ADDR_PCTL ({`IRL_IDX_PCTL, 2'b00})
`define IRL_ADDR_STAT ({`IRL_IDX_STAT, 2'b00})

// ********************************************************************
// field positions of the rate configuration register and of the PCTL register
// ********************************************************************
`define IRL_CFG_PORT_BIT 6
`define IRL_CFG_PPS_BIT 5
`define IRL_CFG_FC_BIT 4
`define IRL_CFG_MODE_HI 3
`define IRL_CFG_MODE_LO 2
`define IRL_CFG_IFG_BIT 1
`define IRL_CFG_PRE_BIT 0
`define IRL_PCTL_FCEN_BIT 0

// ********************************************************************
// reset values and encodings
// ********************************************************************
`define IRL_CFG_RST 7'h00
`define IRL_CODE_RST 7'h00
`define IRL_PCTL_RST 1'b0
`define IRL_MODE_ALL 2'b00
`define IRL_MODE_BMF 2'b01
`define IRL_MODE_BM 2'b10
`define IRL_MODE_B 2'b11
`define IRL_SPD_10 2'b00
`define IRL_SPD_100 2'b01
`define IRL_SPD_1000 2'b10
`define IRL_RATE_OPEN 32'hFFFFFFFF

// ********************************************************************
// per-frame overhead bytes, rate code table limits and measurement window timing
// ********************************************************************
`define IRL_IFG_BYTES 32'h0000000C
`define IRL_PRE_BYTES 32'h00000008
`define IRL_CODE_MAX_LOW 7'h0A
`define IRL_CODE_MAX_MID 7'h64
`define IRL_CODE_MAX 7'h73
`define IRL_WINDOW_NS 1000000000
`define IRL_CLK_NS 20

`endif

// file: rtl/irl_rate_lut.v
// translation of a 7-bit rate code and link speed into an allowed rate per second
`include "irl_regs.vh"

module irl_rate_lut (
  // code and context
  input wire [6:0] code,
  input wire [1:0] speed,
  input wire pps,
  // allowed rate, bits or packets per second
  output reg [31:0] rate,
  output reg valid
);

  // ********************************************************************
  // helpers
  // ********************************************************************
  // scale the code by a constant, kept in 32 bits on purpose
  function [31:0] mul_code;
    input [6:0] c;
    input [31:0] k;
    begin
      mul_code = {25'h0000000, c} * k;
    end
  endfunction

  wire [6:0] low_step;
  assign low_step = code - 7'h64; // 1..15 for the low-rate codes

  // ********************************************************************
  // lookup, invalid combinations report valid low so the caller holds
  // ********************************************************************
  always @* begin
    rate = `IRL_RATE_OPEN;
    valid = 1'b0;
    if (speed != 2'b11) begin
      if (code == 7'h00) begin
        // full link rate
        valid = 1'b1;
        case (speed)
          `IRL_SPD_10: rate = pps ? 32'h00004B00 : 32'h00989680;
          `IRL_SPD_100: rate = pps ? 32'h0002EE00 : 32'h05F5E100;
          default: rate = pps ? 32'h001D4C00 : 32'h3B9ACA00;
        endcase
      end else if (code <= `IRL_CODE_MAX_LOW) begin
        // linear 1 Mb/s steps, packet steps by speed
        valid = 1'b1;
        if (!pps)
          rate = mul_code(code, 32'h000F4240);
        else if (speed == `IRL_SPD_1000)
          rate = mul_code(code, 32'h00004B00);
        else
          rate = mul_code(code, 32'h00000780);
      end else if (code <= `IRL_CODE_MAX_MID) begin
        // 10 Mb/s links stay at full rate, no packet figure exists
        if (speed == `IRL_SPD_10) begin
          valid = !pps;
          rate = 32'h00989680;
        end else begin
          valid = 1'b1;
          if (pps)
            rate = (speed == `IRL_SPD_1000) ? mul_code(code, 32'h00004B00) :
                   mul_code(code, 32'h00000780);
          else
            rate = (speed == `IRL_SPD_1000) ? mul_code(code, 32'h00989680) :
                   mul_code(code, 32'h000F4240);
        end
      end else if (code <= `IRL_CODE_MAX) begin
        // fixed low rates per speed
        valid = 1'b1;
        if (pps) begin
          if (low_step == 7'h01)
            rate = (speed == `IRL_SPD_1000) ? 32'h00000280 : 32'h00000040;
          else
            rate = (speed == `IRL_SPD_1000) ? mul_code(low_step - 7'h01, 32'h00000500) :
                   mul_code(low_step - 7'h01, 32'h00000080);
        end else begin
          if (speed == `IRL_SPD_10)
            rate = mul_code(low_step, 32'h0000FA00);
          else if (speed == `IRL_SPD_1000 || low_step <= 7'h03)
            rate = mul_code(low_step, 32'h0009C400);
          else
            rate = mul_code(low_step, 32'h0000FA00);
        end
      end
      // codes above the table stay invalid
    end
  end

endmodule

// file: rtl/irl_ingress_rate_limiter.v
// ingress rate limiter of one switch port with its apb register file
//
// Our own choices: the address map and the APB slave port.
`include "irl_regs.vh"

module irl_ingress_rate_limiter #(
  parameter WINDOW_CYCLES = `IRL_WINDOW_NS / `IRL_CLK_NS,
  parameter LEN_W = 14
) (
  // clock and reset
  input wire sys_clk,
  input wire resetn,
  // apb slave
  input wire [11:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // link state from the mac
  input wire [1:0] link_speed,
  // received frame descriptor, one cycle per frame
  input wire fr_valid,
  input wire [LEN_W-1:0] fr_len,
  input wire fr_bcast,
  input wire fr_mcast,
  input wire fr_flood,
  input wire [2:0] fr_prio,
  // verdict and flow control
  output reg fr_pass,
  output reg fr_drop,
  output reg flow_ctrl_req
);

  // ********************************************************************
  // functions
  // ********************************************************************
  // cost of one frame in the unit that the limit is kept in
  function [31:0] frame_cost;
    input [LEN_W-1:0] len;
    input pps;
    input ifg;
    input pre;
    reg [31:0] bytes;
    begin
      bytes = {{(32-LEN_W){1'b0}}, len};
      if (ifg)
        bytes = bytes + `IRL_IFG_BYTES;
      if (pre && !pps)
        bytes = bytes + `IRL_PRE_BYTES;
      frame_cost = pps ? 32'h00000001 : {bytes[28:0], 3'b000};
    end
  endfunction

  // frame class filter of the limit mode
  function class_match;
    input [1:0] mode;
    input bc;
    input mc;
    input fl;
    begin
      case (mode)
        `IRL_MODE_ALL: class_match = 1'b1;
        `IRL_MODE_BMF: class_match = bc | mc | fl;
        `IRL_MODE_BM: class_match = bc | mc;
        default: class_match = bc;
      endcase
    end
  endfunction

  // ********************************************************************
  // registers
  // ********************************************************************
  reg [6:0] cfg_reg;
  reg [6:0] p0_code_reg;
  reg [6:0] p7_code_reg;
  reg [6:0] act0_reg;
  reg [6:0] act7_reg;
  reg fc_port_en_reg;
  reg [31:0] rate0_reg;
  reg [31:0] rate7_reg;
  reg [31:0] win_cnt_reg;
  reg [31:0] use_mem [0:7];
  reg [7:0] over_reg;
  integer i;

  wire setup_ph;
  wire wr_en;
  // decode on the full byte address so an unaligned access reports an error
  assign setup_ph = psel & ~penable;
  assign wr_en = psel & penable & pready & pwrite;

  // ********************************************************************
  // apb slave: answer in the first access cycle, data latched at setup
  // ********************************************************************
  reg [31:0] rd_mux;
  reg hit;
  always @* begin
    rd_mux = 32'h00000000;
    hit = 1'b1;
    case (paddr)
      `IRL_ADDR_CFG: rd_mux = {25'h0000000, cfg_reg};
      `IRL_ADDR_P0: rd_mux = {25'h0000000, p0_code_reg}; // bit 7 reads zero
      `IRL_ADDR_P7: rd_mux = {25'h0000000, p7_code_reg};
      `IRL_ADDR_PCTL: rd_mux = {31'h00000000, fc_port_en_reg};
      `IRL_ADDR_STAT: rd_mux = {over_reg, 1'b0, act7_reg, 1'b0, act0_reg,
                                7'h00, flow_ctrl_req};
      default: hit = 1'b0;
    endcase
  end

  // bus handshake registers
  // zero wait states; a master that holds penable longer sees pready only once
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready <= setup_ph;
      if (setup_ph) begin
        prdata <= pwrite ? 32'h00000000 : rd_mux;
        pslverr <= ~hit;
      end else if (pready) begin
        prdata <= 32'h00000000;
        pslverr <= 1'b0;
      end
    end
  end

  // ********************************************************************
  // software registers and commit on priority 7 write
  // ********************************************************************
  // the staged code sits in p0_code_reg; the limiter only sees act0_reg
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cfg_reg <= `IRL_CFG_RST;
      p0_code_reg <= `IRL_CODE_RST;
      p7_code_reg <= `IRL_CODE_RST;
      act0_reg <= `IRL_CODE_RST;
      act7_reg <= `IRL_CODE_RST;
      fc_port_en_reg <= `IRL_PCTL_RST;
    end else if (wr_en) begin
      case (paddr)
        `IRL_ADDR_CFG: cfg_reg <= pwdata[6:0];
        `IRL_ADDR_P0: p0_code_reg <= pwdata[6:0];
        `IRL_ADDR_P7: begin
          p7_code_reg <= pwdata[6:0];
          act0_reg <= p0_code_reg; // commit staged code
          act7_reg <= pwdata[6:0];
        end
        `IRL_ADDR_PCTL: fc_port_en_reg <= pwdata[`IRL_PCTL_FCEN_BIT];
        default: ;
      endcase
    end
  end

  // ********************************************************************
  // code to rate translation
  // ********************************************************************
  wire pps_mode;
  wire port_mode;
  wire fc_on;
  wire [31:0] lut0_rate;
  wire [31:0] lut7_rate;
  wire [31:0] full_rate;
  wire lut0_ok;
  wire lut7_ok;
  wire full_ok;
  assign pps_mode = cfg_reg[`IRL_CFG_PPS_BIT];
  assign port_mode = cfg_reg[`IRL_CFG_PORT_BIT];
  assign fc_on = cfg_reg[`IRL_CFG_FC_BIT] & fc_port_en_reg;

  irl_rate_lut u_lut0 (
    .code(act0_reg),
    .speed(link_speed),
    .pps(pps_mode),
    .rate(lut0_rate),
    .valid(lut0_ok)
  );

  irl_rate_lut u_lut7 (
    .code(act7_reg),
    .speed(link_speed),
    .pps(pps_mode),
    .rate(lut7_rate),
    .valid(lut7_ok)
  );

  // outside port mode, priorities without a code of their own run at full link rate
  irl_rate_lut u_lutf (
    .code(`IRL_CODE_RST),
    .speed(link_speed),
    .pps(pps_mode),
    .rate(full_rate),
    .valid(full_ok)
  );

  // a reserved code leaves the last good rate in place
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rate0_reg <= `IRL_RATE_OPEN;
      rate7_reg <= `IRL_RATE_OPEN;
    end else begin
      if (lut0_ok)
        rate0_reg <= lut0_rate;
      if (lut7_ok)
        rate7_reg <= lut7_rate;
    end
  end

  // ********************************************************************
  // one-second measurement window
  // ********************************************************************
  wire win_tick;
  assign win_tick = (win_cnt_reg == WINDOW_CYCLES - 1);

  // free-running window; the budget is refilled whole at each tick
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn)
      win_cnt_reg <= 32'h00000000;
    else if (win_tick)
      win_cnt_reg <= 32'h00000000;
    else
      win_cnt_reg <= win_cnt_reg + 32'h00000001;
  end

  // ********************************************************************
  // frame accounting
  // ********************************************************************
  reg [2:0] idx;
  reg [31:0] limit;
  reg [31:0] base;
  reg [31:0] cost;
  reg [32:0] sum;
  reg counted;
  reg exceed;
  always @* begin
    idx = port_mode ? 3'h0 : fr_prio;
    case (idx)
      3'h0: limit = rate0_reg;
      3'h7: limit = rate7_reg;
      default: limit = full_ok ? full_rate : `IRL_RATE_OPEN;
    endcase
    base = win_tick ? 32'h00000000 : use_mem[idx];
    cost = frame_cost(fr_len, pps_mode, cfg_reg[`IRL_CFG_IFG_BIT],
                      cfg_reg[`IRL_CFG_PRE_BIT]);
    sum = {1'b0, base} + {1'b0, cost};
    counted = class_match(cfg_reg[`IRL_CFG_MODE_HI:`IRL_CFG_MODE_LO],
                          fr_bcast, fr_mcast, fr_flood);
    exceed = counted && (sum > {1'b0, limit});
  end

  // usage counters, window clear, verdicts and flow control
  // a frame that lands on the tick is charged to the new window
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      for (i = 0; i < 8; i = i + 1)
        use_mem[i] <= 32'h00000000;
      over_reg <= 8'h00;
      fr_pass <= 1'b0;
      fr_drop <= 1'b0;
      flow_ctrl_req <= 1'b0;
    end else begin
      if (win_tick) begin
        for (i = 0; i < 8; i = i + 1)
          use_mem[i] <= 32'h00000000;
        over_reg <= 8'h00;
      end
      fr_pass <= fr_valid & (~exceed | fc_on);
      fr_drop <= fr_valid & exceed & ~fc_on;
      if (fr_valid && counted && !exceed)
        use_mem[idx] <= sum[31:0];
      if (fr_valid && exceed)
        over_reg[idx] <= 1'b1;
      // flow control instead of drop, held to the window end
      if (!fc_on)
        flow_ctrl_req <= 1'b0;
      else if (fr_valid && exceed)
        flow_ctrl_req <= 1'b1;
      else if (win_tick)
        flow_ctrl_req <= 1'b0;
    end
  end

endmodule

// file: test/irl_checker.sv
// port-level assertions for the ingress rate limiter
`include "irl_regs.vh"
module irl_checker #(
  parameter WINDOW_CYCLES = 600,
  parameter LEN_W = 14
) (
  // clock and reset
  input wire sys_clk,
  input wire resetn,
  // apb
  input wire [11:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // frames and verdicts
  input wire [1:0] link_speed,
  input wire fr_valid,
  input wire [LEN_W-1:0] fr_len,
  input wire fr_bcast,
  input wire fr_mcast,
  input wire fr_flood,
  input wire [2:0] fr_prio,
  input wire fr_pass,
  input wire fr_drop,
  input wire flow_ctrl_req
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // shadow of what software wrote
  // ****************************************
  reg [6:0] cfg_reg;
  reg [6:0] p0_reg;
  reg fcen_reg;
  wire wr_done = psel && penable && pready && pwrite;
  wire rd_done = psel && penable && pready && !pwrite;
  wire fc_on = cfg_reg[`IRL_CFG_FC_BIT] && fcen_reg;
  wire [1:0] cls = fr_bcast ? 2'h3 : fr_mcast ? 2'h2 : fr_flood ? 2'h1 : 2'h0;
  wire counted = cls >= cfg_reg[`IRL_CFG_MODE_HI:`IRL_CFG_MODE_LO];
  wire mapped = paddr == `IRL_ADDR_CFG || paddr == `IRL_ADDR_P0 || paddr == `IRL_ADDR_P7
    || paddr == `IRL_ADDR_PCTL || paddr == `IRL_ADDR_STAT;
  // writes land at the access edge, as the limiter itself sees them
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cfg_reg <= `IRL_CFG_RST;
      p0_reg <= `IRL_CODE_RST;
      fcen_reg <= `IRL_PCTL_RST;
    end else if (wr_done) begin
      if (paddr == `IRL_ADDR_CFG) cfg_reg <= pwdata[6:0];
      if (paddr == `IRL_ADDR_P0) p0_reg <= pwdata[6:0];
      if (paddr == `IRL_ADDR_PCTL) fcen_reg <= pwdata[0];
    end
  end
  // cycles that flow control has stood; it must drop by the window end
  reg [31:0] fc_cnt;
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn)
      fc_cnt <= 32'h00000000;
    else if (flow_ctrl_req)
      fc_cnt <= fc_cnt + 32'h00000001;
    else
      fc_cnt <= 32'h00000000;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // ****************************************
  // assertions
  // ****************************************
  a_verdict_once: assert property (fr_valid |=> fr_pass != fr_drop)
    else $error("frame got no single verdict");
  a_no_stray: assert property (!fr_valid |=> !fr_pass && !fr_drop)
    else $error("verdict without a frame");
  a_apb_answer: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("apb answer not one cycle after setup");
  a_apb_error: assert property (pready |-> pslverr == !mapped && (mapped || prdata == 32'h0))
    else $error("apb error flag wrong for address");
  a_cfg_readback: assert property (rd_done && paddr == `IRL_ADDR_CFG
    |-> prdata == {25'h0, cfg_reg})
    else $error("config readback differs from written value");
  a_code_readback: assert property (rd_done && paddr == `IRL_ADDR_P0
    |-> prdata == {25'h0, p0_reg})
    else $error("code readback differs from written value");
  a_fc_window: assert property (fc_cnt <= WINDOW_CYCLES)
    else $error("flow control held past a window end");
  a_fc_cause: assert property ($rose(flow_ctrl_req) |-> fr_pass && $past(fc_on))
    else $error("flow control rose without pass under enabled flow control");
  a_fc_no_drop: assert property (fr_valid && fc_on |=> !fr_drop)
    else $error("frame dropped while flow control mode active");
  a_uncounted_pass: assert property (fr_valid && !counted |=> fr_pass)
    else $error("uncounted frame class was not passed");
  c_drop: cover property (fr_valid ##1 fr_drop);
  c_fc: cover property ($rose(flow_ctrl_req));
  c_err: cover property (pready && pslverr);
endmodule

bind irl_ingress_rate_limiter irl_checker #(.WINDOW_CYCLES(WINDOW_CYCLES), .LEN_W(LEN_W))
  irl_checker_inst (.sys_clk, .resetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
  .pready, .pslverr, .link_speed, .fr_valid, .fr_len, .fr_bcast, .fr_mcast, .fr_flood,
  .fr_prio, .fr_pass, .fr_drop, .flow_ctrl_req);

// file: test/irl_mac_model.sv
// receive mac model: feeds frame descriptors and tallies verdicts
module irl_mac_model #(
  parameter LEN_W = 14
) (
  // clock
  input wire sys_clk,
  // frame descriptor
  output logic fr_valid,
  output logic [LEN_W-1:0] fr_len,
  output logic fr_bcast,
  output logic fr_mcast,
  output logic fr_flood,
  output logic [2:0] fr_prio,
  // verdicts
  input wire fr_pass,
  input wire fr_drop
);
  timeunit 1ns;
  timeprecision 1ps;
  int n_pass = 0;
  int n_drop = 0;
  // ****************************************
  // descriptor driver and verdict tally
  // ****************************************
  initial begin
    fr_valid = 1'b0;
    fr_len = '0;
    {fr_bcast, fr_mcast, fr_flood, fr_prio} = 6'h00;
  end
  // verdicts come one cycle after each frame
  always @(posedge sys_clk) begin
    if (fr_pass === 1'b1) n_pass <= n_pass + 1;
    if (fr_drop === 1'b1) n_drop <= n_drop + 1;
  end
  // k back-to-back frames; class 0 unicast, 1 flood, 2 multicast, 3 broadcast
  task automatic burst(input int len, input int c, input int p, input int k);
    repeat (k) begin
      fr_valid <= 1'b1;
      fr_len <= len[LEN_W-1:0];
      fr_bcast <= c == 3;
      fr_mcast <= c == 2;
      fr_flood <= c == 1;
      fr_prio <= p[2:0];
      @(posedge sys_clk);
    end
    // stale fields keep moving so nothing relies on them outside a frame
    fr_valid <= 1'b0;
    fr_len <= ~fr_len;
    fr_prio <= ~fr_prio;
    fr_flood <= ~fr_flood;
  endtask
endmodule

// file: test/irl_ingress_rate_limiter_tb_top.sv
// testbench of the ingress rate limiter
`include "irl_regs.vh"
module irl_ingress_rate_limiter_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, resetn, psel, penable, pwrite, pready, pslverr, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [1:0] link_speed;
  logic fr_valid, fr_bcast, fr_mcast, fr_flood, fr_pass, fr_drop, flow_ctrl_req;
  logic [13:0] fr_len;
  logic [2:0] fr_prio;
  int n_mismatch = 0;
  int compares = 0;
  // short window keeps each budget inside a few hundred cycles
  irl_ingress_rate_limiter #(.WINDOW_CYCLES(600), .LEN_W(14)) irl_ingress_rate_limiter_inst (
    .sys_clk, .resetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
    .link_speed, .fr_valid, .fr_len, .fr_bcast, .fr_mcast, .fr_flood, .fr_prio, .fr_pass,
    .fr_drop, .flow_ctrl_req);
  irl_mac_model #(.LEN_W(14)) irl_mac_model_inst (.sys_clk, .fr_valid, .fr_len, .fr_bcast,
    .fr_mcast, .fr_flood, .fr_prio, .fr_pass, .fr_drop);
  // ****************************************
  // bus and check tasks
  // ****************************************
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  // one apb transfer; read data and error kept in q and e
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int t = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      t++;
    end while (pready !== 1'b1 && t < 50);
    if (t >= 50) chk("apb answer", 32'h1, 32'h0);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic setup(input logic [7:0] cfg, input logic [6:0] code, input logic [1:0] spd);
    apb(1'b1, `IRL_ADDR_CFG, {24'h0, cfg});
    apb(1'b1, `IRL_ADDR_P0, {25'h0, code});
    apb(1'b1, `IRL_ADDR_P7, 32'h0);
    link_speed <= spd;
  endtask
  // fill a window until a drop, then wait for the first pass of the next one
  task automatic sync(input int len);
    int d0 = irl_mac_model_inst.n_drop;
    int p0;
    int t = 0;
    while (irl_mac_model_inst.n_drop == d0 && t < 500) begin
      irl_mac_model_inst.burst(len, 3, 0, 1);
      repeat (2) @(posedge sys_clk);
      t++;
    end
    p0 = irl_mac_model_inst.n_pass;
    while (irl_mac_model_inst.n_pass == p0 && t < 1000) begin
      irl_mac_model_inst.burst(len, 3, 0, 1);
      repeat (2) @(posedge sys_clk);
      t++;
    end
    if (t >= 1000) chk("window sync", 32'h1, 32'h0);
  endtask
  // budget of n frames: one spent in sync, n-1 more pass, last drops
  task automatic row(input logic [7:0] cfg, input logic [6:0] code, input logic [1:0] spd,
      input int len, input int n);
    int p0;
    setup(cfg, code, spd);
    sync(len);
    p0 = irl_mac_model_inst.n_pass;
    irl_mac_model_inst.burst(len, 3, 0, n);
    repeat (2) @(posedge sys_clk);
    chk("passes in window", n - 1, irl_mac_model_inst.n_pass - p0);
  endtask
  // exhaust a 64-packet budget at 10 Mb/s
  task automatic fill(input logic [7:0] cfg);
    setup(cfg, 7'h65, 2'h0);
    sync(780);
    irl_mac_model_inst.burst(780, 3, 0, 63);
    repeat (2) @(posedge sys_clk);
  endtask
  task automatic probe(input int c, input int p, input logic exp);
    int n0 = irl_mac_model_inst.n_pass;
    irl_mac_model_inst.burst(780, c, p, 1);
    repeat (2) @(posedge sys_clk);
    chk("frame passed", {31'h0, exp}, irl_mac_model_inst.n_pass - n0);
  endtask
  task summarize;
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // ****************************************
  // test sequence
  // ****************************************
  initial begin
    {resetn, psel, penable, pwrite, paddr, pwdata, link_speed} = '0;
    repeat (4) @(posedge sys_clk);
    resetn <= 1'b1;
    apb(1'b0, `IRL_ADDR_CFG, 32'h0);
    chk("cfg reset", 32'h0, q);
    apb(1'b0, `IRL_ADDR_P0, 32'h0);
    chk("code reset", 32'h0, q);
    apb(1'b1, `IRL_ADDR_CFG, 32'hFFFFFFFF);
    apb(1'b0, `IRL_ADDR_CFG, 32'h0);
    chk("cfg readback", 32'h7F, q);
    apb(1'b1, `IRL_ADDR_P0, 32'hFFFFFFFF);
    apb(1'b0, `IRL_ADDR_P0, 32'h0);
    chk("code readback", 32'h7F, q);
    apb(1'b0, `IRL_ADDR_STAT, 32'h0);
    chk("code before commit", 32'h0, {25'h0, q[14:8]});
    apb(1'b1, `IRL_ADDR_P7, 32'h0);
    apb(1'b0, `IRL_ADDR_STAT, 32'h0);
    chk("code after commit", 32'h7F, {25'h0, q[14:8]});
    apb(1'b0, 12'h100, 32'h0);
    chk("unmapped error", {31'h0, 1'b1}, {31'h0, e});
    chk("unmapped data", 32'h0, q);
    $display("test registers done");
    row(8'h03, 7'h65, 2'h2, 780, 100);
    row(8'h03, 7'h74, 2'h2, 780, 100);
    row(8'h02, 7'h65, 2'h2, 780, 101);
    row(8'h00, 7'h65, 2'h2, 780, 102);
    row(8'h23, 7'h65, 2'h0, 780, 64);
    row(8'h20, 7'h66, 2'h1, 780, 128);
    row(8'h03, 7'h01, 2'h1, 9980, 12);
    row(8'h03, 7'h0B, 2'h1, 16360, 83);
    row(8'h03, 7'h65, 2'h0, 780, 10);
    row(8'h03, 7'h00, 2'h0, 16383, 76);
    row(8'h03, 7'h32, 2'h0, 16383, 76);
    $display("test rates done");
    for (int m = 0; m < 4; m++) begin
      fill(8'h20 | 8'(m << 2));
      for (int c = 0; c < 4; c++) probe(c, 0, c < m);
    end
    $display("test frame classes done");
    for (int pm = 0; pm < 2; pm++) begin
      fill(8'h20 | 8'(pm << 6));
      probe(0, 3, pm == 0);
    end
    $display("test port mode done");
    fill(8'h20);
    apb(1'b1, `IRL_ADDR_CFG, 32'h30);
    probe(0, 0, 1'b0);
    chk("flow control idle", 32'h0, {31'h0, flow_ctrl_req});
    apb(1'b1, `IRL_ADDR_PCTL, 32'h1);
    fill(8'h20);
    apb(1'b1, `IRL_ADDR_CFG, 32'h30);
    probe(0, 0, 1'b1);
    chk("flow control raised", 32'h1, {31'h0, flow_ctrl_req});
    $display("test flow control done");
    summarize;
  end
  // watchdog
  initial begin
    repeat (90000) @(posedge sys_clk);
    n_mismatch++;
    summarize;
  end
endmodule
